// [rtcbk_edge.sv]
// Purpose: rising-edge detector turning a slow clock level into a core-clock enable
// Assumes: input is synchronous to core_clk
// Notes:   one pulse per rising edge of the slow level
`timescale 1ns/1ps
module rtcbk_edge (
	input  wire logic core_clk, // core clock
	input  wire logic srst,     // synchronous reset
	input  wire logic lvl,      // slow level
	output logic      rise      // one-cycle pulse on rising edge
);
	logic lvl_r;

	// remember previous level
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lvl_r <= lvl; // start from the live level: no false edge after reset
		end else begin
			lvl_r <= lvl;
		end
	end

	assign rise = lvl & ~lvl_r;
endmodule

// [rtcbk_pkg.sv]
// Purpose: shared constants and types for the real-time clock with backup store
// Assumes: one core clock; low-speed sources arrive as synchronous level inputs
// Notes:   widths, divider limits and the reload, counter, alarm and backup resets live here
package rtcbk_pkg;

	// clock source selection codes
	typedef enum logic [1:0] {
		RTCBK_SRC_NONE = 2'h0,
		RTCBK_SRC_LSE  = 2'h1,
		RTCBK_SRC_LSI  = 2'h2,
		RTCBK_SRC_FAST = 2'h3
	} rtcbk_src_t;

	// widths
	localparam int         RTCBK_PRESC_W    = 20;
	localparam int         RTCBK_CNT_W      = 32;
	localparam int         RTCBK_BKP_W      = 16;
	localparam int         RTCBK_BKP_N      = 10;
	localparam int         RTCBK_BKP_IDX_W  = 4;

	// reset values
	localparam logic [19:0] RTCBK_RELOAD_RST = 20'h07FFF;
	localparam logic [31:0] RTCBK_CNT_RST    = 32'h00000000;
	localparam logic [31:0] RTCBK_ALARM_RST  = 32'hFFFFFFFF;
	localparam logic [15:0] RTCBK_BKP_RST    = 16'h0000;

	// fast external clock divided by 128: toggle every 64 edges
	localparam logic [6:0]  RTCBK_FAST_DIV_LAST = 7'h7F;
	// 32768 Hz / 512 Hz = 64 low-speed ticks per output period
	localparam logic [5:0]  RTCBK_CAL_DIV_LAST  = 6'h3F;
	localparam int          RTCBK_CAL_HALF_BIT  = 5;

	// pick one of the low-speed levels
	function automatic logic rtcbk_pick(input logic [1:0] sel, input logic lse, input logic lsi,
		input logic fast);
		case (sel)
			2'h1:    rtcbk_pick = lse;
			2'h2:    rtcbk_pick = lsi;
			2'h3:    rtcbk_pick = fast;
			default: rtcbk_pick = 1'b0;
		endcase
	endfunction

endpackage

// [rtcbk_props.sv]
// Purpose: port assertions for the rtc block
// Assumes: one core clock domain
// Notes:   bound to every rtcbk_top instance
`timescale 1ns/1ps
module rtcbk_props (
	input wire logic        core_clk,     // clock
	input wire logic        srst,         // core reset
	input wire logic        bkp_rst,      // battery reset
	input wire logic        cnt_wr,       // counter load
	input wire logic        alarm_ie,     // alarm enable
	input wire logic        sec_ie,       // tick enable
	input wire logic        alarm_clr,    // alarm clear
	input wire logic        sec_clr,      // tick clear
	input wire logic [3:0]  bkp_idx,      // backup index
	input wire logic [15:0] bkp_rdata,    // backup data
	input wire logic [31:0] cnt_value,    // counter
	input wire logic        alarm_flag,   // alarm flag
	input wire logic        sec_flag,     // tick flag
	input wire logic        alarm_irq,    // alarm irq
	input wire logic        sec_irq,      // tick irq
	input wire logic        event_alarm,  // event pulse
	input wire logic        standby_wake  // wake request
);
	// one domain, both resets disable
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst || bkp_rst);
	// irq gating and wake routing
	a_alarm_irq_gate: assert property (alarm_irq == (alarm_flag && alarm_ie)) else $error("alarm irq");
	a_sec_irq_gate: assert property (sec_irq == (sec_flag && sec_ie)) else $error("sec irq");
	a_wake_follows: assert property (standby_wake == alarm_flag) else $error("wake");
	a_event_one_cycle: assert property (event_alarm |=> !event_alarm) else $error("event width");
	a_event_flag: assert property (event_alarm |-> alarm_flag) else $error("event flag");
	// counter only steps by one and each step sets the tick flag
	a_cnt_step: assert property (!$past(cnt_wr) && $changed(cnt_value) |->
		cnt_value == $past(cnt_value) + 32'h1 && sec_flag) else $error("cnt step");
	a_sec_sticky: assert property (sec_flag && !sec_clr |=> sec_flag) else $error("sec sticky");
	a_alarm_sticky: assert property (alarm_flag && !alarm_clr |=> alarm_flag) else $error("alarm sticky");
	a_bkp_unmapped: assert property (bkp_idx >= 4'hA |=> bkp_rdata == 16'h0000) else $error("bkp high");
	// main scenarios
	cover property (event_alarm);
	cover property ($rose(sec_flag));
	cover property ($fell(alarm_flag));
endmodule
bind rtcbk_top rtcbk_props chk_u (.core_clk, .srst, .bkp_rst, .cnt_wr, .alarm_ie, .sec_ie, .alarm_clr, .sec_clr,
	.bkp_idx, .bkp_rdata, .cnt_value, .alarm_flag, .sec_flag, .alarm_irq, .sec_irq, .event_alarm, .standby_wake);

// [rtcbk_top.sv]
// Purpose: real-time clock with prescaler, counter, alarm, periodic flag and backup store
// Assumes: srst models loss of core power only; backup state uses bkp_rst (battery domain)
// Notes:   no software bus; controls and status are plain ports
//          the time path and the flags sit in the battery domain and ignore srst
//          switching the source may cut or stretch the tick period in progress
//          the reference output is gated in a flop so the pin never glitches
// Contract
// - programmable 32-bit counter advances on every time-base tick.
// - alarm raised when counter reaches the compare value.
// - 20-bit prescaler produces tick; reset gives one tick per second at 32768 Hz.
// - two interrupt sources: alarm match and periodic time-base.
// - source is low-speed crystal, low-power oscillator, or fast clock divided by 128.
// - a 512 Hz reference output is derived from the clock for calibration.
// - ten 16-bit backup registers held in the battery domain.
// - backup contents survive Standby while core state is lost.
// - block and its source keep running in Stop and Standby; the 512 Hz reference divider and output reset on srst.
// - alarm event drives an external event line to wake from Stop.
// - alarm event is a Standby exit condition.
`timescale 1ns/1ps
module rtcbk_top (
	input  wire logic        core_clk,      // 125 MHz core clock
	input  wire logic        srst,          // core-domain reset, active high
	input  wire logic        bkp_rst,       // battery-domain reset, active high
	input  wire logic [1:0]  src_sel,       // clock source select
	input  wire logic        lse_clk,       // low-speed crystal level
	input  wire logic        lsi_clk,       // low-power oscillator level
	input  wire logic        fast_external_oscillator, // fast external clock level
	input  wire logic        reload_wr,     // load prescaler reload
	input  wire logic [19:0] reload_wdata,  // prescaler reload value
	input  wire logic        cnt_wr,        // load counter
	input  wire logic [31:0] cnt_wdata,     // counter value
	input  wire logic        alarm_wr,      // load compare value
	input  wire logic [31:0] alarm_wdata,   // compare value
	input  wire logic        alarm_ie,      // alarm interrupt enable
	input  wire logic        sec_ie,        // periodic interrupt enable
	input  wire logic        alarm_clr,     // clear alarm flag
	input  wire logic        sec_clr,       // clear periodic flag
	input  wire logic        cal_en,        // enable 512 Hz output
	input  wire logic        bkp_wr,        // write backup register
	input  wire logic [3:0]  bkp_idx,       // backup register index
	input  wire logic [15:0] bkp_wdata,     // backup write data
	output logic [15:0]      bkp_rdata,     // backup read data
	output logic [31:0]      cnt_value,     // running counter
	output logic [19:0]      presc_value,   // prescaler remaining count
	output logic             alarm_flag,    // sticky alarm flag
	output logic             sec_flag,      // sticky periodic flag
	output logic             alarm_irq,     // alarm interrupt
	output logic             sec_irq,       // periodic interrupt
	output logic             event_alarm,   // alarm pulse to external_event_lines
	output logic             standby_wake,  // alarm standby exit request
	output logic             cal_out        // 512 Hz reference
);
	logic [6:0]  fast_div_r;
	logic [6:0]  fast_div_nxt;
	logic        fast_lvl;
	logic        fast_rise;
	logic        src_lvl;
	logic        src_rise;
	logic [19:0] reload_r;
	logic [19:0] presc_r;
	logic [19:0] presc_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic [31:0] alarm_r;
	logic        alarm_flag_r;
	logic        sec_flag_r;
	logic        event_r;
	logic [5:0]  cal_div_r;
	logic        cal_r;
	logic        cal_out_r;
	logic [15:0] bkp_r [0:9];
	logic [15:0] bkp_rd_r;
	logic        tick;
	logic        match;
	logic        alarm_flag_nxt;
	logic        sec_flag_nxt;
	logic        bkp_in_range;

	// the whole time path runs on the battery reset only: a core reset in Standby
	// must neither lose nor invent a source edge

	// count only rising edges of the fast clock
	// edge detectors start from the live level, so no false edge follows reset
	rtcbk_edge u_fast_edge (
		.core_clk (core_clk),
		.srst     (bkp_rst),
		.lvl      (fast_external_oscillator),
		.rise     (fast_rise)
	);

	// fast clock divided by 128: 7-bit count of its edges, top bit is the divided level
	assign fast_div_nxt = (fast_div_r == rtcbk_pkg::RTCBK_FAST_DIV_LAST) ? 7'h00 : fast_div_r + 7'h01;
	assign fast_lvl     = fast_div_r[6];
	always_ff @(posedge core_clk) begin
		if (bkp_rst) begin
			fast_div_r <= 7'h00;
		end else if (fast_rise) begin
			fast_div_r <= fast_div_nxt;
		end
	end

	// select source and form one enable from the selected level
	// a source switch may give one stray edge; only the current tick period is affected
	assign src_lvl = rtcbk_pkg::rtcbk_pick(src_sel, lse_clk, lsi_clk, fast_lvl);
	rtcbk_edge u_src_edge (
		.core_clk (core_clk),
		.srst     (bkp_rst),
		.lvl      (src_lvl),
		.rise     (src_rise)
	);

	// prescaler: divide by reload plus one
	// a reload write restarts the divider, so the next tick is a full period away
	assign tick      = src_rise && (presc_r == 20'h00000);
	assign presc_nxt = tick ? reload_r : presc_r - 20'h00001;
	always_ff @(posedge core_clk) begin
		if (bkp_rst) begin
			reload_r <= rtcbk_pkg::RTCBK_RELOAD_RST;
			presc_r  <= rtcbk_pkg::RTCBK_RELOAD_RST;
		end else if (reload_wr) begin
			reload_r <= reload_wdata;
			presc_r  <= reload_wdata;
		end else if (src_rise) begin
			presc_r <= presc_nxt;
		end
	end

	// counter: software load wins, else advance per tick
	// a load that meets a tick drops that step and its match
	assign cnt_nxt = cnt_wr ? cnt_wdata : (tick ? cnt_r + 32'h00000001 : cnt_r);
	always_ff @(posedge core_clk) begin
		if (bkp_rst) begin
			cnt_r   <= rtcbk_pkg::RTCBK_CNT_RST;
			alarm_r <= rtcbk_pkg::RTCBK_ALARM_RST;
		end else begin
			cnt_r <= cnt_nxt;
			if (alarm_wr) begin
				alarm_r <= alarm_wdata;
			end
		end
	end

	// match when counter steps onto the compare value
	// compare against the value about to be taken, so the flag rises with the step
	assign match = tick && !cnt_wr && ((cnt_r + 32'h00000001) == alarm_r);

	// sticky flags, set wins over clear
	assign alarm_flag_nxt = match | (alarm_flag_r & ~alarm_clr);
	assign sec_flag_nxt   = tick | (sec_flag_r & ~sec_clr);
	always_ff @(posedge core_clk) begin
		if (bkp_rst) begin
			alarm_flag_r <= 1'b0;
			sec_flag_r   <= 1'b0;
			event_r      <= 1'b0;
		end else begin
			alarm_flag_r <= alarm_flag_nxt;
			sec_flag_r   <= sec_flag_nxt;
			event_r      <= match;
		end
	end

	// 512 Hz reference: toggle every 32 input clocks
	// bit 5 of a 6-bit count of source edges flips every 32 edges
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cal_div_r <= 6'h00;
			cal_r     <= 1'b0;
		end else if (src_rise) begin
			cal_div_r <= cal_div_r + 6'h01;
			cal_r     <= cal_div_r[rtcbk_pkg::RTCBK_CAL_HALF_BIT];
		end
	end

	// gate the reference in a flop so the pin never sees a glitch from the enable
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cal_out_r <= 1'b0;
		end else begin
			cal_out_r <= cal_r & cal_en;
		end
	end

	// index decode shared by write and read; indices 10 to 15 are refused
	assign bkp_in_range = (bkp_idx < 4'(rtcbk_pkg::RTCBK_BKP_N));

	// backup store, only battery reset clears it
	always_ff @(posedge core_clk) begin
		if (bkp_rst) begin
			for (int i = 0; i < rtcbk_pkg::RTCBK_BKP_N; i++) begin
				bkp_r[i] <= rtcbk_pkg::RTCBK_BKP_RST;
			end
		end else if (bkp_wr && bkp_in_range) begin
			bkp_r[bkp_idx] <= bkp_wdata;
		end
	end

	// registered read, out-of-range index reads zero
	// the read flop is core-domain only; the store itself keeps its contents
	always_ff @(posedge core_clk) begin
		if (srst) begin
			bkp_rd_r <= 16'h0000;
		end else begin
			bkp_rd_r <= bkp_in_range ? bkp_r[bkp_idx] : 16'h0000;
		end
	end

	// outputs
	// interrupts are flag and enable; the wake request follows the sticky alarm flag
	assign bkp_rdata    = bkp_rd_r;
	assign cnt_value    = cnt_r;
	assign presc_value  = presc_r;
	assign alarm_flag   = alarm_flag_r;
	assign sec_flag     = sec_flag_r;
	assign alarm_irq    = alarm_flag_r & alarm_ie;
	assign sec_irq      = sec_flag_r & sec_ie;
	assign event_alarm  = event_r;
	assign standby_wake = alarm_flag_r;
	assign cal_out      = cal_out_r;

endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the rtc block
// Assumes: source levels come from a free cycle counter
// Notes:   reload set to 3 so ticks stay short
`timescale 1ns/1ps
module tb_top;
	logic        core_clk = 1'b0, srst = 1'b1, bkp_rst = 1'b1, reload_wr = 1'b0, cnt_wr = 1'b0, alarm_wr = 1'b0;
	logic        alarm_ie = 1'b0, sec_ie = 1'b0, alarm_clr = 1'b0, sec_clr = 1'b0, cal_en = 1'b0, bkp_wr = 1'b0;
	logic [1:0]  src_sel = 2'h0;
	logic [2:0]  ph = 3'h0;
	logic [3:0]  bkp_idx = 4'h0;
	logic [15:0] bkp_wdata = 16'h0000, bkp_rdata;
	logic [19:0] reload_wdata = 20'h00003, presc_value;
	logic [31:0] cnt_wdata = 32'hFFFFFFFF, alarm_wdata = 32'h00000001, cnt_value, cval;
	logic        alarm_flag, sec_flag, alarm_irq, sec_irq, event_alarm, standby_wake, cal_out;
	int          errors = 0, total_checks = 0, per[4] = '{0, 4, 8, 256};
	// source levels: periods of 2, 4 and 8 core cycles
	wire         fast_external_oscillator = ph[0], lse_clk = ph[1], lsi_clk = ph[2];
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) ph <= #1 ph + 3'h1;
	rtcbk_top dut_u (.core_clk, .srst, .bkp_rst, .src_sel, .lse_clk, .lsi_clk, .fast_external_oscillator,
		.reload_wr, .reload_wdata, .cnt_wr, .cnt_wdata, .alarm_wr, .alarm_wdata, .alarm_ie, .sec_ie,
		.alarm_clr, .sec_clr, .cal_en, .bkp_wr, .bkp_idx, .bkp_wdata, .bkp_rdata, .cnt_value, .presc_value,
		.alarm_flag, .sec_flag, .alarm_irq, .sec_irq, .event_alarm, .standby_wake, .cal_out);
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// one bounded step of a wait
	task automatic step(inout int n);
		cyc(1);
		n++;
		if (n > 3000) begin
			errors++;
			test_done();
		end
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// cycles between two changes of the counter or of the reference output
	task automatic span(input logic cal, input int exp);
		int n;
		for (int k = 0; k < 2; k++) begin
			cval = cal ? {31'h0, cal_out} : cnt_value;
			n = 0;
			while ((cal ? {31'h0, cal_out} : cnt_value) === cval) step(n);
		end
		chk(cal ? "cal gap" : "tick gap", exp, n);
	endtask
	task automatic t_rate();
		chk("presc reset", 32'h7FFF, presc_value);
		chk("cnt reset", 32'h0, cnt_value);
		reload_wr = 1'b1;
		cyc(1);
		reload_wr = 1'b0;
		for (int s = 1; s < 4; s++) begin
			src_sel = s[1:0];
			span(1'b0, 4 * per[s]);
		end
		src_sel = 2'h0;
		cyc(4);
		cval = cnt_value;
		cyc(300);
		chk("no source", cval, cnt_value);
		$display("rate test done");
	endtask
	task automatic t_alarm();
		int n = 0;
		src_sel = 2'h1;
		alarm_ie = 1'b1;
		cnt_wr = 1'b1;
		alarm_wr = 1'b1;
		cyc(1);
		cnt_wr = 1'b0;
		alarm_wr = 1'b0;
		while (event_alarm !== 1'b1) step(n);
		chk("cnt at match", 32'h1, cnt_value);
		chk("wake", 32'h1, standby_wake);
		chk("alarm irq", 32'h1, alarm_irq);
		alarm_ie = 1'b0;
		src_sel = 2'h0;
		cyc(3);
		chk("alarm masked", 32'h0, alarm_irq);
		chk("sec flag", 32'h1, sec_flag);
		chk("sec masked", 32'h0, sec_irq);
		sec_ie = 1'b1;
		cyc(1);
		chk("sec irq", 32'h1, sec_irq);
		sec_clr = 1'b1;
		alarm_clr = 1'b1;
		cyc(1);
		sec_clr = 1'b0;
		alarm_clr = 1'b0;
		chk("cleared", 32'h0, {sec_flag, alarm_flag, standby_wake, sec_irq});
		$display("alarm test done");
	endtask
	task automatic t_backup();
		int n = 1;
		src_sel = 2'h1;
		bkp_wr = 1'b1;
		for (int k = 0; k < 11; k++) begin
			bkp_idx = k[3:0];
			bkp_wdata = 16'hA5F0 ^ k[15:0];
			cyc(1);
		end
		bkp_wr = 1'b0;
		span(1'b0, 4 * per[1]);
		cval = cnt_value;
		srst = 1'b1;
		sec_clr = 1'b1;
		cyc(1);
		srst = 1'b0;
		chk("sec cleared", 32'h0, {31'h0, sec_flag});
		while (cnt_value === cval) step(n);
		chk("tick across reset", 4 * per[1], n);
		chk("cnt kept", cval + 32'h1, cnt_value);
		chk("set beats clear", 32'h1, {31'h0, sec_flag});
		sec_clr = 1'b0;
		src_sel = 2'h0;
		for (int k = 0; k < 12; k++) begin
			bkp_idx = k[3:0];
			cyc(1);
			chk("backup", k < 10 ? 32'hA5F0 ^ k : 32'h0, {16'h0, bkp_rdata});
		end
		$display("backup test done");
	endtask
	task automatic t_cal();
		src_sel = 2'h1;
		cal_en = 1'b1;
		span(1'b1, 32 * per[1]);
		cal_en = 1'b0;
		cyc(1);
		chk("cal off", 32'h0, {31'h0, cal_out});
		$display("cal test done");
	endtask
	initial begin
		cyc(5);
		srst = 1'b0;
		bkp_rst = 1'b0;
		t_rate();
		t_alarm();
		t_backup();
		t_cal();
		test_done();
	end
endmodule
